// ### spi_slave_pkg.sv
// constants shared by the spi slave controller and its fifo
// assumes a single 100 MHz system clock domain
package spi_slave_pkg;

   // ==========================================================
   // configuration values
   localparam logic [2:0] MODE_SPI = 3'h2;
   localparam int CHAR_BITS = 8;
   localparam int FIFO_DEPTH = 4;
   localparam int DMA_COUNT_W = 16;
   localparam logic [7:0] BUSY_TOKEN = 8'hFF;
   localparam logic [2:0] LAST_BIT = 3'h7;
   localparam logic [2:0] FIRST_BIT = 3'h0;

   // ==========================================================
   // reset values
   localparam logic [7:0] CHAR_RST = 8'h00;
   localparam logic FLAG_CLR_RST = 1'b0;
   localparam logic FLAG_SET_RST = 1'b1;

   // ==========================================================
   // interrupt source positions
   localparam int IRQ_TX_IDLE = 0;
   localparam int IRQ_TX_FREE = 1;
   localparam int IRQ_RX_VALID = 2;
   localparam int IRQ_TX_DMA_A = 3;
   localparam int IRQ_TX_DMA_B = 4;
   localparam int IRQ_RX_DMA_A = 5;
   localparam int IRQ_RX_DMA_B = 6;
   localparam int IRQ_RX_OVERRUN = 7;
   localparam int IRQ_TX_UNDERRUN = 8;
   localparam int IRQ_COUNT = 9;

   // ==========================================================
   // select edge save field positions
   localparam int SEL_SAVED_A = 0;
   localparam int SEL_SAVED_B = 1;
   localparam int SEL_EXTRA_EDGE = 2;

   // ==========================================================
   // link states
   typedef enum logic [0:0] {
      LINK_IDLE = 1'b0,
      LINK_FRAME = 1'b1
   } link_state_type;

endpackage

// ### byte_fifo_if.sv
// signals between a fifo and its user
// assumes both sides on clk_sys_i
`timescale 1ns/1ps
interface byte_fifo_if #(parameter int WIDTH = 8);
   logic push;
   logic [WIDTH-1:0] wdata;
   logic pop;
   logic [WIDTH-1:0] rdata;
   logic full;
   logic empty;

   modport store (input push, input wdata, input pop, output rdata, output full, output empty);
   modport user (output push, output wdata, output pop, input rdata, input full, input empty);
endinterface

// ### char_fifo.sv
// character fifo with full and empty
// assumes push ignored when full and pop ignored when empty
`timescale 1ns/1ps
module char_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = spi_slave_pkg::FIFO_DEPTH
)
(
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   byte_fifo_if.store port
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wptr_r;
   logic [AW-1:0] rptr_r;
   logic [AW:0] count_r;
   logic do_push;
   logic do_pop;

   assign do_push = port.push & (count_r != (AW+1)'(DEPTH));
   assign do_pop = port.pop & (count_r != '0);
   assign port.full = (count_r == (AW+1)'(DEPTH));
   assign port.empty = (count_r == '0);
   assign port.rdata = mem_r[rptr_r];

   // ==========================================================
   // storage
   always_ff @(posedge clk_sys_i)
   begin
      if (do_push)
      begin
         mem_r[wptr_r] <= port.wdata;
      end
   end

   // ==========================================================
   // pointers and count
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_b_i)
      begin
         wptr_r <= '0;
         rptr_r <= '0;
         count_r <= '0;
      end
      else
      begin
         if (do_push)
         begin
            wptr_r <= (wptr_r == AW'(DEPTH-1)) ? '0 : wptr_r + 1'b1;
         end
         if (do_pop)
         begin
            rptr_r <= (rptr_r == AW'(DEPTH-1)) ? '0 : rptr_r + 1'b1;
         end
         count_r <= count_r + (AW+1)'(do_push) - (AW+1)'(do_pop);
      end
   end
endmodule

// ### spi_slave_serial_controller.sv
// spi slave controller: serial link, tx/rx fifos, status, dma count save, irq
// assumes pins are asynchronous and software/dma ports run on clk_sys_i
`timescale 1ns/1ps
// Functional notes
// - polarity, phase and bit order choose frame format; order set means lsb first.
// - miso driven and mosi sampled only while select is asserted.
// - a falling select edge clears the receive shift register and bit count; when enabled it loads the transmit shift register.
// - separate four-entry transmit and receive fifos.
// - data write pushes transmit fifo; data read pops receive fifo.
// - dma channels fill and drain the fifos through the same ports.
// - storing a received character sets receive valid.
// - character into full receive fifo is dropped, overflow set, overrun irq raised.
// - dma overrun shows after fifo drains; cleared by dma reset or reload.
// - each received character shifts out one transmit character together.
// - empty transmit fifo raises underrun and sends last character or 0xFF.
// - write into empty fifo and serializer clears transmit idle.
// - transmit free clears on fifo full, sets on each character shifted out.
// - transmit idle sets when fifo empty and last character shifted.
// - after select and receive valid, a pad byte precedes data into empty fifo.
// - on select rise with rx dma, first edge after load saves active count.
// - three-bit field records what was saved and extra select edges.
// - idle, free and valid bits interrupt on rise or level per mode.
// - dma buffer a/b completion interrupts on active bit falling.
// - receive overrun and transmit underrun also interrupt.
module spi_slave_serial_controller #(
   parameter int CHAR_W = spi_slave_pkg::CHAR_BITS,
   parameter int DEPTH = spi_slave_pkg::FIFO_DEPTH,
   parameter int CNT_W = spi_slave_pkg::DMA_COUNT_W
)
(
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   input wire logic [2:0] controller_mode_i,
   input wire logic master_select_bit_i,
   input wire logic clock_polarity_bit_i,
   input wire logic clock_phase_bit_i,
   input wire logic bit_order_bit_i,
   input wire logic repeat_last_select_i,
   input wire logic irq_trigger_mode_i,
   input wire logic sclk_i,
   input wire logic slave_select_n_i,
   input wire logic mosi_i,
   output logic miso_o,
   output logic miso_oe_o,
   input wire logic data_wr_i,
   input wire logic [CHAR_W-1:0] data_wdata_i,
   input wire logic data_rd_i,
   input wire logic tx_dma_wr_i,
   input wire logic [CHAR_W-1:0] tx_dma_wdata_i,
   input wire logic rx_dma_rd_i,
   output logic [CHAR_W-1:0] data_rdata_o,
   output logic rx_valid_flag_o,
   output logic rx_overflow_flag_o,
   output logic tx_idle_flag_o,
   output logic tx_free_flag_o,
   input wire logic rx_dma_enable_i,
   input wire logic [1:0] tx_buffer_active_ab_i,
   input wire logic [1:0] rx_buffer_active_ab_i,
   input wire logic [1:0] rx_buffer_load_i,
   input wire logic rx_dma_reset_i,
   input wire logic [CNT_W-1:0] rx_dma_count_a_i,
   input wire logic [CNT_W-1:0] rx_dma_count_b_i,
   output logic rx_dma_error_o,
   output logic [CNT_W-1:0] rx_count_saved_o,
   output logic [2:0] select_edge_save_field_o,
   input wire logic [spi_slave_pkg::IRQ_COUNT-1:0] irq_enable_i,
   input wire logic [spi_slave_pkg::IRQ_COUNT-1:0] irq_flag_clear_i,
   input wire logic unit_top_irq_enable_i,
   output logic [spi_slave_pkg::IRQ_COUNT-1:0] irq_flag_o,
   output logic irq_o
);
   localparam int NIRQ = spi_slave_pkg::IRQ_COUNT;

   // ==========================================================
   // shift helpers
   function automatic logic [CHAR_W-1:0] shift_char(input logic [CHAR_W-1:0] sh,
                                                    input logic in_bit,
                                                    input logic lsb_first);
      if (lsb_first)
      begin
         shift_char = {in_bit, sh[CHAR_W-1:1]};
      end
      else
      begin
         shift_char = {sh[CHAR_W-2:0], in_bit};
      end
   endfunction

   function automatic logic head_bit(input logic [CHAR_W-1:0] sh, input logic lsb_first);
      head_bit = lsb_first ? sh[0] : sh[CHAR_W-1];
   endfunction

   // ==========================================================
   // pin synchronisers
   logic sclk_s1_r, sclk_s2_r, sclk_d_r;
   logic ssn_s1_r, ssn_s2_r, ssn_d_r;
   logic mosi_s1_r, mosi_s2_r;

   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_b_i)
      begin
         sclk_s1_r <= 1'b0;
         sclk_s2_r <= 1'b0;
         sclk_d_r <= 1'b0;
         ssn_s1_r <= 1'b1;
         ssn_s2_r <= 1'b1;
         ssn_d_r <= 1'b1;
         mosi_s1_r <= 1'b0;
         mosi_s2_r <= 1'b0;
      end
      else
      begin
         sclk_s1_r <= sclk_i;
         sclk_s2_r <= sclk_s1_r;
         sclk_d_r <= sclk_s2_r;
         ssn_s1_r <= slave_select_n_i;
         ssn_s2_r <= ssn_s1_r;
         ssn_d_r <= ssn_s2_r;
         mosi_s1_r <= mosi_i;
         mosi_s2_r <= mosi_s1_r;
      end
   end

   // ==========================================================
   // edge decode
   spi_slave_pkg::link_state_type state_r;
   logic enabled, in_frame, ss_fall, ss_rise, sck_now, sck_was, lead_ev, trail_ev;
   logic sample_ev, shift_ev, byte_done, tx_load;
   logic [2:0] bit_cnt_r;

   assign enabled = (controller_mode_i == spi_slave_pkg::MODE_SPI) & ~master_select_bit_i;
   assign ss_fall = ssn_d_r & ~ssn_s2_r;
   assign ss_rise = ~ssn_d_r & ssn_s2_r;
   assign in_frame = (state_r == spi_slave_pkg::LINK_FRAME) & ~ssn_s2_r;
   assign sck_now = sclk_s2_r ^ clock_polarity_bit_i;
   assign sck_was = sclk_d_r ^ clock_polarity_bit_i;
   assign lead_ev = sck_now & ~sck_was;
   assign trail_ev = ~sck_now & sck_was;
   assign sample_ev = in_frame & (clock_phase_bit_i ? trail_ev : lead_ev);
   assign shift_ev = in_frame & (clock_phase_bit_i ? lead_ev
                                                    : (trail_ev & (bit_cnt_r != 3'h0)));
   assign byte_done = sample_ev & (bit_cnt_r == spi_slave_pkg::LAST_BIT);
   assign tx_load = (ss_fall & enabled) | byte_done;

   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_b_i)
      begin
         state_r <= spi_slave_pkg::LINK_IDLE;
      end
      else
      begin
         case (state_r)
            spi_slave_pkg::LINK_IDLE:
            begin
               if (ss_fall & enabled)
               begin
                  state_r <= spi_slave_pkg::LINK_FRAME;
               end
            end
            spi_slave_pkg::LINK_FRAME:
            begin
               if (ss_rise | ~enabled)
               begin
                  state_r <= spi_slave_pkg::LINK_IDLE;
               end
            end
            default:
            begin
               state_r <= spi_slave_pkg::LINK_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // fifos
   byte_fifo_if #(.WIDTH(CHAR_W)) tx_f ();
   byte_fifo_if #(.WIDTH(CHAR_W)) rx_f ();

   char_fifo #(.WIDTH(CHAR_W), .DEPTH(DEPTH)) tx_fifo_u (
      .clk_sys_i(clk_sys_i),
      .rst_b_i(rst_b_i),
      .port(tx_f.store)
   );

   char_fifo #(.WIDTH(CHAR_W), .DEPTH(DEPTH)) rx_fifo_u (
      .clk_sys_i(clk_sys_i),
      .rst_b_i(rst_b_i),
      .port(rx_f.store)
   );

   logic pad_due_r, pad_arm_r, busy_r, underrun, rx_overrun, rx_pop;
   logic [CHAR_W-1:0] rx_sh_r, tx_sh_r, last_tx_r, fill_val, load_val;

   assign tx_f.push = data_wr_i | tx_dma_wr_i;
   assign tx_f.wdata = data_wr_i ? data_wdata_i : tx_dma_wdata_i;
   assign fill_val = repeat_last_select_i ? last_tx_r : spi_slave_pkg::BUSY_TOKEN;
   assign underrun = tx_load & ~pad_due_r & tx_f.empty;
   assign tx_f.pop = tx_load & ~pad_due_r;
   assign load_val = (pad_due_r | tx_f.empty) ? fill_val : tx_f.rdata;
   assign rx_pop = data_rd_i | rx_dma_rd_i;
   assign rx_f.pop = rx_pop;
   assign rx_f.push = byte_done & ~rx_f.full;
   assign rx_f.wdata = shift_char(rx_sh_r, mosi_s2_r, bit_order_bit_i);
   assign rx_overrun = byte_done & rx_f.full;

   // ==========================================================
   // shift registers and miso
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_b_i)
      begin
         bit_cnt_r <= spi_slave_pkg::FIRST_BIT;
         rx_sh_r <= spi_slave_pkg::CHAR_RST;
         tx_sh_r <= spi_slave_pkg::CHAR_RST;
         last_tx_r <= spi_slave_pkg::CHAR_RST;
         miso_o <= 1'b0;
      end
      else
      begin
         if (ss_fall)
         begin
            bit_cnt_r <= spi_slave_pkg::FIRST_BIT;
            rx_sh_r <= spi_slave_pkg::CHAR_RST;
         end
         else if (sample_ev)
         begin
            bit_cnt_r <= bit_cnt_r + 3'h1;
            rx_sh_r <= shift_char(rx_sh_r, mosi_s2_r, bit_order_bit_i);
         end
         if (tx_load)
         begin
            last_tx_r <= load_val;
            if (clock_phase_bit_i)
            begin
               tx_sh_r <= load_val;
            end
            else
            begin
               miso_o <= head_bit(load_val, bit_order_bit_i);
               tx_sh_r <= shift_char(load_val, 1'b0, bit_order_bit_i);
            end
         end
         else if (shift_ev)
         begin
            miso_o <= head_bit(tx_sh_r, bit_order_bit_i);
            tx_sh_r <= shift_char(tx_sh_r, 1'b0, bit_order_bit_i);
         end
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_b_i)
      begin
         miso_oe_o <= 1'b0;
      end
      else
      begin
         miso_oe_o <= enabled & ~ssn_s2_r & (state_r == spi_slave_pkg::LINK_FRAME);
      end
   end

   // ==========================================================
   // padding control
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_b_i)
      begin
         pad_arm_r <= 1'b0;
         pad_due_r <= 1'b0;
      end
      else
      begin
         if (ssn_s2_r)
         begin
            pad_arm_r <= 1'b0;
         end
         else if (rx_valid_flag_o)
         begin
            pad_arm_r <= 1'b1;
         end
         if (ssn_s2_r)
         begin
            pad_due_r <= 1'b0;
         end
         else if (pad_arm_r & tx_f.push & tx_f.empty & ~tx_f.pop)
         begin
            pad_due_r <= 1'b1;
         end
         else if (tx_load)
         begin
            pad_due_r <= 1'b0;
         end
      end
   end

   // ==========================================================
   // status flags
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_b_i)
      begin
         busy_r <= spi_slave_pkg::FLAG_CLR_RST;
         tx_idle_flag_o <= spi_slave_pkg::FLAG_SET_RST;
         tx_free_flag_o <= spi_slave_pkg::FLAG_SET_RST;
         rx_valid_flag_o <= spi_slave_pkg::FLAG_CLR_RST;
         rx_overflow_flag_o <= spi_slave_pkg::FLAG_CLR_RST;
      end
      else
      begin
         if (tx_load)
         begin
            busy_r <= ~underrun;
         end
         tx_idle_flag_o <= tx_f.empty & ~tx_f.push & ~busy_r & ~pad_due_r;
         if (tx_f.full & ~tx_f.pop)
         begin
            tx_free_flag_o <= 1'b0;
         end
         else if (byte_done)
         begin
            tx_free_flag_o <= 1'b1;
         end
         rx_valid_flag_o <= ~rx_f.empty | rx_f.push;
         if (rx_overrun)
         begin
            rx_overflow_flag_o <= 1'b1;
         end
         else if (rx_pop)
         begin
            rx_overflow_flag_o <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_b_i)
      begin
         data_rdata_o <= spi_slave_pkg::CHAR_RST;
      end
      else if (rx_pop & ~rx_f.empty)
      begin
         data_rdata_o <= rx_f.rdata;
      end
   end

   // ==========================================================
   // dma overrun and saved count
   logic ovf_wait_r, save_arm_r;

   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_b_i)
      begin
         ovf_wait_r <= 1'b0;
         rx_dma_error_o <= 1'b0;
      end
      else
      begin
         if (rx_overrun)
         begin
            ovf_wait_r <= 1'b1;
         end
         else if (rx_dma_reset_i | (ovf_wait_r & rx_f.empty))
         begin
            ovf_wait_r <= 1'b0;
         end
         if (ovf_wait_r & rx_f.empty & ~rx_overrun)
         begin
            rx_dma_error_o <= 1'b1;
         end
         else if (rx_dma_reset_i | (|rx_buffer_load_i))
         begin
            rx_dma_error_o <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_b_i)
      begin
         save_arm_r <= 1'b0;
         rx_count_saved_o <= '0;
         select_edge_save_field_o <= 3'h0;
      end
      else
      begin
         if (|rx_buffer_load_i)
         begin
            save_arm_r <= 1'b1;
            select_edge_save_field_o <= 3'h0;
         end
         else if (ss_rise & rx_dma_enable_i)
         begin
            if (save_arm_r)
            begin
               save_arm_r <= 1'b0;
               if (rx_buffer_active_ab_i[0])
               begin
                  rx_count_saved_o <= rx_dma_count_a_i;
                  select_edge_save_field_o[spi_slave_pkg::SEL_SAVED_A] <= 1'b1;
               end
               else if (rx_buffer_active_ab_i[1])
               begin
                  rx_count_saved_o <= rx_dma_count_b_i;
                  select_edge_save_field_o[spi_slave_pkg::SEL_SAVED_B] <= 1'b1;
               end
            end
            else
            begin
               select_edge_save_field_o[spi_slave_pkg::SEL_EXTRA_EDGE] <= 1'b1;
            end
         end
      end
   end

   // ==========================================================
   // interrupts
   logic [NIRQ-1:0] src_lvl, src_prev_r, src_set;
   logic [1:0] tx_act_prev_r, rx_act_prev_r;

   assign src_lvl = {{6{1'b0}}, rx_valid_flag_o, tx_free_flag_o, tx_idle_flag_o};

   always_comb
   begin
      src_set = irq_trigger_mode_i ? src_lvl : (src_lvl & ~src_prev_r);
      src_set[spi_slave_pkg::IRQ_TX_DMA_A] = tx_act_prev_r[0] & ~tx_buffer_active_ab_i[0];
      src_set[spi_slave_pkg::IRQ_TX_DMA_B] = tx_act_prev_r[1] & ~tx_buffer_active_ab_i[1];
      src_set[spi_slave_pkg::IRQ_RX_DMA_A] = rx_act_prev_r[0] & ~rx_buffer_active_ab_i[0];
      src_set[spi_slave_pkg::IRQ_RX_DMA_B] = rx_act_prev_r[1] & ~rx_buffer_active_ab_i[1];
      src_set[spi_slave_pkg::IRQ_RX_OVERRUN] = rx_overrun;
      src_set[spi_slave_pkg::IRQ_TX_UNDERRUN] = underrun;
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_b_i)
      begin
         src_prev_r <= '0;
         tx_act_prev_r <= 2'h0;
         rx_act_prev_r <= 2'h0;
         irq_flag_o <= '0;
         irq_o <= 1'b0;
      end
      else
      begin
         src_prev_r <= src_lvl;
         tx_act_prev_r <= tx_buffer_active_ab_i;
         rx_act_prev_r <= rx_buffer_active_ab_i;
         irq_flag_o <= src_set | (irq_flag_o & ~irq_flag_clear_i);
         irq_o <= unit_top_irq_enable_i & (|(irq_flag_o & irq_enable_i));
      end
   end
endmodule

// ### spi_slave_serial_controller_monitor.sv
// port assertions for the spi slave controller
// assumes one clk_sys_i domain; bound to the top module
`timescale 1ns/1ps
module spi_slave_serial_controller_monitor
(
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   input wire logic slave_select_n_i,
   input wire logic miso_oe_o,
   input wire logic data_wr_i,
   input wire logic tx_dma_wr_i,
   input wire logic tx_free_flag_o,
   input wire logic tx_idle_flag_o,
   input wire logic rx_valid_flag_o,
   input wire logic rx_overflow_flag_o,
   input wire logic [1:0] tx_buffer_active_ab_i,
   input wire logic [1:0] rx_buffer_active_ab_i,
   input wire logic [spi_slave_pkg::IRQ_COUNT-1:0] irq_enable_i,
   input wire logic unit_top_irq_enable_i,
   input wire logic [spi_slave_pkg::IRQ_COUNT-1:0] irq_flag_o,
   input wire logic irq_o
);
   // ==========================================
   // assertions
   default clocking mon_cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!rst_b_i);
   oe_select_a: assert property (slave_select_n_i [*6] |-> !miso_oe_o)
      else $error("miso driven while deselected");
   irq_line_a: assert property (
      irq_o == $past(unit_top_irq_enable_i && |(irq_flag_o & irq_enable_i)))
      else $error("irq line wrong");
   overrun_irq_a: assert property ($rose(rx_overflow_flag_o) |-> ##[0:1] irq_flag_o[7])
      else $error("overflow without overrun flag");
   free_by_push_a: assert property ($fell(tx_free_flag_o) |->
      $past(data_wr_i || tx_dma_wr_i) || $past(data_wr_i || tx_dma_wr_i, 2))
      else $error("free cleared without push");
   idle_by_push_a: assert property ($fell(tx_idle_flag_o) |->
      $past(data_wr_i || tx_dma_wr_i) || $past(data_wr_i || tx_dma_wr_i, 2))
      else $error("idle cleared without push");
   valid_irq_a: assert property ($rose(rx_valid_flag_o) |-> ##[0:2] irq_flag_o[2])
      else $error("valid rise without flag");
   rx_done_a: assert property ($fell(rx_buffer_active_ab_i[0]) |-> ##[0:2] irq_flag_o[5])
      else $error("rx buffer done without flag");
   tx_done_a: assert property ($fell(tx_buffer_active_ab_i[1]) |-> ##[0:2] irq_flag_o[4])
      else $error("tx buffer done without flag");
endmodule
bind spi_slave_serial_controller spi_slave_serial_controller_monitor monitor_inst (.*);

// ### spi_master_model.sv
// spi master model driving clock, select and mosi
// assumes clk_i is the bench clock; framing follows pol_i and pha_i
`timescale 1ns/1ps
module spi_master_model
(
   input wire logic clk_i,
   input wire logic miso_i,
   input wire logic lsb_i,
   input wire logic pol_i,
   input wire logic pha_i,
   output logic sclk_o,
   output logic ss_n_o,
   output logic mosi_o
);
   // ==========================================
   // frame driver
   initial
   begin
      sclk_o = 1'h0;
      ss_n_o = 1'h1;
      mosi_o = 1'h0;
   end
   task automatic wt(input int n);
      repeat (n) @(negedge clk_i);
   endtask
   task automatic xfer(input logic [7:0] tx, input logic last, output logic [7:0] rx);
      int k;
      if (ss_n_o)
      begin
         sclk_o = pol_i;
         ss_n_o = 1'h0;
         wt(8);
      end
      for (int i = 0; i < 8; i++)
      begin
         k = lsb_i ? i : 7 - i;
         if (!pha_i)
            mosi_o = tx[k];
         wt(4);
         if (!pha_i)
            rx[k] = miso_i;
         sclk_o = ~pol_i;
         if (pha_i)
            mosi_o = tx[k];
         wt(4);
         if (pha_i)
            rx[k] = miso_i;
         sclk_o = pol_i;
      end
      if (last)
      begin
         wt(4);
         ss_n_o = 1'h1;
         mosi_o = ~mosi_o;
         wt(8);
      end
   endtask
endmodule

// ### testbench.sv
// self-checking bench for the spi slave controller
// assumes the master model drives the serial pins
`timescale 1ns/1ps
module testbench;
   // ==========================================
   // signals and instances
   logic clk_sys_i = 1'h0, rst_b_i = 1'h0, master_select_bit_i = 1'h0;
   logic clock_polarity_bit_i = 1'h0, clock_phase_bit_i = 1'h0, bit_order_bit_i = 1'h0;
   logic repeat_last_select_i = 1'h1, irq_trigger_mode_i = 1'h0, unit_top_irq_enable_i = 1'h0;
   logic data_wr_i = 1'h0, data_rd_i = 1'h0, tx_dma_wr_i = 1'h0, rx_dma_rd_i = 1'h0;
   logic rx_dma_enable_i = 1'h0, rx_dma_reset_i = 1'h0;
   logic [2:0] controller_mode_i = 3'h2;
   logic [7:0] data_wdata_i = 8'h00, tx_dma_wdata_i = 8'h00, data_rdata_o;
   logic [1:0] tx_buffer_active_ab_i = 2'h0, rx_buffer_active_ab_i = 2'h0;
   logic [1:0] rx_buffer_load_i = 2'h0;
   logic [15:0] rx_dma_count_a_i = 16'h0000, rx_dma_count_b_i = 16'h0000, rx_count_saved_o;
   logic [8:0] irq_enable_i = 9'h000, irq_flag_clear_i = 9'h000, irq_flag_o;
   logic sclk_i, slave_select_n_i, mosi_i, miso_o, miso_oe_o, rx_valid_flag_o, irq_o;
   logic rx_overflow_flag_o, tx_idle_flag_o, tx_free_flag_o, rx_dma_error_o;
   logic [2:0] select_edge_save_field_o;
   int err_count = 0;
   int comparisons = 0;
   spi_slave_serial_controller spi_slave_serial_controller_inst (.*);
   spi_master_model spi_master_model_inst (.clk_i(clk_sys_i),
      .miso_i(miso_oe_o ? miso_o : ~miso_o), .pol_i(clock_polarity_bit_i),
      .pha_i(clock_phase_bit_i), .lsb_i(bit_order_bit_i), .sclk_o(sclk_i),
      .ss_n_o(slave_select_n_i), .mosi_o(mosi_i));
   always #5 clk_sys_i = ~clk_sys_i;
   // ==========================================
   // helpers
   task automatic wt(input int n);
      repeat (n) @(negedge clk_sys_i);
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         err_count++;
         $display("unexpected at %0t: saw %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic push(input logic dma, input logic [7:0] v);
      data_wr_i = !dma;
      tx_dma_wr_i = dma;
      data_wdata_i = v;
      tx_dma_wdata_i = v;
      wt(1);
      data_wr_i = 1'h0;
      tx_dma_wr_i = 1'h0;
      wt(1);
   endtask
   task automatic pop(input logic dma, input logic [7:0] exp);
      data_rd_i = !dma;
      rx_dma_rd_i = dma;
      wt(1);
      data_rd_i = 1'h0;
      rx_dma_rd_i = 1'h0;
      chk(16'(data_rdata_o), 16'(exp));
      wt(1);
   endtask
   task automatic frame(input logic [7:0] mo, input logic [7:0] exp, input logic last);
      logic [7:0] got;
      spi_master_model_inst.xfer(mo, last, got);
      chk(16'(got), 16'(exp));
   endtask
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // ==========================================
   // scenarios
   task automatic t_fifo();
      chk(16'(tx_idle_flag_o), 16'h1);
      chk(16'(miso_oe_o), 16'h0);
      push(1'h0, 8'hA5);
      chk(16'(tx_idle_flag_o), 16'h0);
      push(1'h1, 8'h3C);
      push(1'h0, 8'h5A);
      push(1'h0, 8'hC3);
      chk(16'(tx_free_flag_o), 16'h0);
      push(1'h0, 8'h99);
      frame(8'h11, 8'hA5, 1'h0);
      chk(16'(tx_free_flag_o), 16'h1);
      frame(8'h22, 8'h3C, 1'h0);
      frame(8'h33, 8'h5A, 1'h0);
      frame(8'h44, 8'hC3, 1'h1);
      chk(16'(tx_idle_flag_o), 16'h1);
      chk(16'(rx_valid_flag_o), 16'h1);
   endtask
   task automatic t_under();
      irq_flag_clear_i = 9'h180;
      wt(1);
      irq_flag_clear_i = 9'h000;
      chk(16'(irq_flag_o[8:7]), 16'h0);
      frame(8'h55, 8'hC3, 1'h1);
      chk(16'(irq_flag_o[8]), 16'h1);
      chk(16'(rx_overflow_flag_o), 16'h1);
      chk(16'(irq_flag_o[7]), 16'h1);
      pop(1'h0, 8'h11);
      pop(1'h1, 8'h22);
      pop(1'h0, 8'h33);
      pop(1'h0, 8'h44);
      chk(16'(rx_dma_error_o), 16'h1);
   endtask
   task automatic t_pad();
      repeat_last_select_i = 1'h0;
      bit_order_bit_i = 1'h1;
      frame(8'h01, 8'hFF, 1'h0);
      push(1'h0, 8'h6E);
      frame(8'h02, 8'hFF, 1'h0);
      frame(8'h03, 8'hFF, 1'h0);
      frame(8'h04, 8'h6E, 1'h1);
      pop(1'h0, 8'h01);
      pop(1'h0, 8'h02);
   endtask
   task automatic t_mode();
      clock_polarity_bit_i = 1'h1;
      clock_phase_bit_i = 1'h1;
      bit_order_bit_i = 1'h0;
      push(1'h0, 8'hB4);
      frame(8'h96, 8'hB4, 1'h1);
      pop(1'h0, 8'h03);
      pop(1'h0, 8'h04);
      pop(1'h0, 8'h96);
   endtask
   task automatic t_dma();
      rx_dma_enable_i = 1'h1;
      rx_buffer_active_ab_i = 2'h1;
      rx_dma_count_a_i = 16'h1234;
      rx_dma_count_b_i = 16'h0BAD;
      rx_buffer_load_i = 2'h1;
      wt(1);
      rx_buffer_load_i = 2'h0;
      chk(16'(rx_dma_error_o), 16'h0);
      frame(8'h66, 8'hFF, 1'h1);
      chk(rx_count_saved_o, 16'h1234);
      chk(16'(select_edge_save_field_o), 16'h1);
      rx_dma_count_a_i = 16'h5678;
      frame(8'h77, 8'hFF, 1'h1);
      chk(rx_count_saved_o, 16'h1234);
      chk(16'(select_edge_save_field_o), 16'h5);
      rx_dma_reset_i = 1'h1;
      wt(1);
      rx_dma_reset_i = 1'h0;
   endtask
   task automatic t_irq();
      irq_trigger_mode_i = 1'h1;
      irq_enable_i = 9'h020;
      unit_top_irq_enable_i = 1'h1;
      rx_buffer_active_ab_i = 2'h0;
      tx_buffer_active_ab_i = 2'h2;
      wt(3);
      chk(16'(irq_flag_o[5]), 16'h1);
      chk(16'(irq_o), 16'h1);
      tx_buffer_active_ab_i = 2'h0;
      irq_flag_clear_i = 9'h021;
      wt(1);
      irq_flag_clear_i = 9'h000;
      wt(3);
      chk(16'(irq_flag_o[5]), 16'h0);
      chk(16'(irq_flag_o[4]), 16'h1);
      chk(16'(irq_o), 16'h0);
      chk(16'(irq_flag_o[0]), 16'h1);
   endtask
   // ==========================================
   // sequence and watchdog
   initial
   begin
      wt(8);
      rst_b_i = 1'h1;
      wt(1);
      t_fifo();
      t_under();
      t_pad();
      t_mode();
      t_dma();
      t_irq();
      summarize();
   end
   initial
   begin
      repeat (20000) @(posedge clk_sys_i);
      err_count++;
      summarize();
   end
endmodule
